// ===== dpf_pkg.sv
// package for the dynamic pin function block: register map, function codes, timing
package dpf_pkg;
    // register word offsets
    localparam logic [3:0] ADDR_FUNC = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h1;
    localparam logic [3:0] ADDR_STAT = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
    localparam logic [3:0] ADDR_REPORT = 4'h6;
    localparam logic [3:0] ADDR_ALIGN = 4'h7;
    // function select field: pin n uses bits [5n+4:5n]
    localparam int FUNC_W = 5;
    localparam int NPIN = 3;
    localparam logic [31:0] FUNC_RST = 32'h0000_0000;
    // ctrl bits
    localparam int CTRL_FIX_LSB = 0;
    localparam int CTRL_TVALID = 3;
    localparam int CTRL_CORR = 4;
    // fix type codes
    localparam logic [2:0] FIX_NONE = 3'h0;
    localparam logic [2:0] FIX_2D = 3'h1;
    // status bits
    localparam int ST_GNSS_OFF = 0;
    localparam int ST_PRES_OFF = 1;
    localparam int ST_STILL = 2;
    localparam int ST_REV_DIR = 3;
    localparam int ST_REV_ALIGN = 4;
    localparam int ST_TVALID = 5;
    localparam int ST_EVT1 = 6;
    localparam int ST_EVT2 = 7;
    localparam int ST_PPS = 8;
    // irq event bits
    localparam int IRQ_W = 6;
    localparam int EV_ZERO = 0;
    localparam int EV_STATE = 1;
    localparam int EV_RAW = 2;
    localparam int EV_EXT_PPS = 3;
    localparam int EV_EVT1 = 4;
    localparam int EV_EVT2 = 5;
    // report-sent strobe bit in the report register
    localparam int REP_DONE = 0;
    typedef enum logic [4:0] {
        FN_INACTIVE = 5'b00000,
        FN_PPS_OUT = 5'b00001,
        FN_FIX_OUT = 5'b00010,
        FN_STILL_IN = 5'b00011,
        FN_GNSS_OFF = 5'b00100,
        FN_PRES_OFF = 5'b00101,
        FN_ZERO_ALIGN = 5'b00110,
        FN_STATE_TRIG = 5'b00111,
        FN_RAW_TRIG = 5'b01000,
        FN_EXT_PPS = 5'b01001,
        FN_EVT1 = 5'b01010,
        FN_EVT2 = 5'b01011,
        FN_DIR_FWD_LO = 5'b01100,
        FN_DIR_FWD_HI = 5'b01101,
        FN_REV_FWD_LO = 5'b01110,
        FN_REV_FWD_HI = 5'b01111
    } dpf_func_t;
    // timing
    localparam longint CLK_HZ = 25000000;
    localparam int PPS_PULSE_MS = 50;
    localparam int PPS_START_MS = 100;
    localparam int PPS_PERIOD_MS = 1000;
    localparam int PULSE_CYC = int'(CLK_HZ * PPS_PULSE_MS / 1000);
    localparam int START_CYC = int'(CLK_HZ * PPS_START_MS / 1000);
    localparam int PERIOD_CYC = int'(CLK_HZ * PPS_PERIOD_MS / 1000);
endpackage

// ===== dpf_pins.sv
// dynamic pin function block: two general purpose pins and the auxiliary port
`timescale 1ns/1ps

// Function
// R1: each pin carries one selected function; inactive leaves driver high-impedance
// R2: second pulse output holds low, pulses high 50 ms each second
// R3: pulses start about 100 ms after reset, regardless of time validity
// R4: time correction restarts the second, may give one interval under 1 s
// R5: auxiliary line marks the second falling, general pins rising
// R6: time-valid flag shows whether time and second pulse are accurate
// R7: fix output low for none or 2D, high for better fixes
// R8: stationary input: high means stationary, low possibly moving
// R9: satellite disable input: low enables, high disables
// R10: pressure disable input: low enables, high disables
// R11: zero-alignment input rising edge zeroes the present orientation
// R12: pin-set alignment is volatile, lost at reset; host makes it permanent
// R13: state-report trigger rising edge requests one state report
// R14: raw-sensor trigger rising edge requests one raw sensor report
// R15: external party debounces switches on edge-triggered inputs
// R16: external pulse input rising edge synchronises the time base
// R17: event inputs set event bit on rising edge, cleared after next report
// R18: direction input level gives reversing indication, polarity per variant
// R19: alignment reversal input level reverses alignment, polarity per variant
module dpf_pins #(
    parameter int START_CYCLES = dpf_pkg::START_CYC,
    parameter int PERIOD_CYCLES = dpf_pkg::PERIOD_CYC,
    parameter int PULSE_CYCLES = dpf_pkg::PULSE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    input wire logic [dpf_pkg::NPIN-1:0] pin_in_i,
    output logic [dpf_pkg::NPIN-1:0] pin_out_o,
    output logic [dpf_pkg::NPIN-1:0] pin_oe_o,
    output logic gnss_disable_o,
    output logic pressure_disable_o,
    output logic stationary_o,
    output logic reverse_dir_o,
    output logic reverse_align_o,
    output logic zero_align_o,
    output logic state_report_req_o,
    output logic raw_report_req_o,
    output logic ext_pps_o,
    output logic time_valid_o,
    output logic irq_o
);
    import dpf_pkg::*;

    localparam int AUX = NPIN - 1;

    logic [31:0] func_r;
    logic [31:0] ctrl_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_en_r;
    logic [NPIN-1:0] pin_prev_r;
    logic evt1_r;
    logic evt2_r;
    logic align_set_r;
    logic [31:0] sec_cnt_r;
    logic [31:0] sec_cnt_nxt;
    logic started_r;
    logic corr_prev_r;
    logic rd_ack_r;
    logic [31:0] rdata_r;
    logic [1:0] resp_r;

    // function held in one pin's select field
    function automatic dpf_func_t fn_of(input logic [31:0] sel, input int n);
        fn_of = dpf_func_t'(sel[n*FUNC_W +: FUNC_W]);
    endfunction

    // level in a given mode on any pin, for level inputs
    function automatic logic lvl_of(input logic [31:0] sel, input logic [NPIN-1:0] pins, input dpf_func_t f);
        lvl_of = 1'b0;
        for (int n = 0; n < NPIN; n++) begin
            if (fn_of(sel, n) == f && pins[n]) begin
                lvl_of = 1'b1;
            end
        end
    endfunction

    // mode selected on any pin
    function automatic logic sel_any(input logic [31:0] sel, input dpf_func_t f);
        sel_any = 1'b0;
        for (int n = 0; n < NPIN; n++) begin
            if (fn_of(sel, n) == f) begin
                sel_any = 1'b1;
            end
        end
    endfunction

    // ==========================================================
    // bus decode
    wire wr_func = avs_write_i && avs_address_i == ADDR_FUNC;
    wire wr_ctrl = avs_write_i && avs_address_i == ADDR_CTRL;
    wire wr_en = avs_write_i && avs_address_i == ADDR_IRQ_EN;
    wire wr_clr = avs_write_i && avs_address_i == ADDR_IRQ_CLR;
    wire wr_rep = avs_write_i && avs_address_i == ADDR_REPORT;
    wire wr_align = avs_write_i && avs_address_i == ADDR_ALIGN;
    wire map_hit = avs_address_i <= ADDR_ALIGN;
    wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                           {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    // report strobe from the report engine: ends latched events
    wire report_done = wr_rep && avs_writedata_i[REP_DONE] && avs_byteenable_i[0];

    // ==========================================================
    // rising edges on each pin, qualified by function
    wire [NPIN-1:0] rise = pin_in_i & ~pin_prev_r;
    logic [NPIN-1:0] rise_zero, rise_state, rise_raw, rise_pps, rise_e1, rise_e2;
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_edge
            assign rise_zero[g] = rise[g] && fn_of(func_r, g) == FN_ZERO_ALIGN; // R11
            assign rise_state[g] = rise[g] && fn_of(func_r, g) == FN_STATE_TRIG; // R13
            assign rise_raw[g] = rise[g] && fn_of(func_r, g) == FN_RAW_TRIG; // R14
            assign rise_pps[g] = rise[g] && fn_of(func_r, g) == FN_EXT_PPS; // R16
            assign rise_e1[g] = rise[g] && fn_of(func_r, g) == FN_EVT1; // R17
            assign rise_e2[g] = rise[g] && fn_of(func_r, g) == FN_EVT2; // R17
        end
    endgenerate
    wire [IRQ_W-1:0] events = {|rise_e2, |rise_e1, |rise_pps, |rise_raw, |rise_state, |rise_zero};

    // ==========================================================
    // second pulse generator
    wire corr_req = ctrl_r[CTRL_CORR];
    wire corr_edge = corr_req && !corr_prev_r; // R4
    wire ext_sync = |rise_pps; // R16
    wire sec_restart = corr_edge || ext_sync;
    // before the first pulse the counter runs to the start delay
    wire sec_wrap = started_r ? sec_cnt_r == 32'(PERIOD_CYCLES - 1) : sec_cnt_r == 32'(START_CYCLES - 1);
    // restart drops the current second short; never waits for time valid
    assign sec_cnt_nxt = (sec_restart || sec_wrap) ? 32'h0000_0000 : sec_cnt_r + 32'h0000_0001; // R3 R4
    wire pps_lvl = started_r && sec_cnt_r < 32'(PULSE_CYCLES); // R2

    // fix quality: none and 2D read low
    wire [2:0] fix_type = ctrl_r[CTRL_FIX_LSB +: 3];
    wire fix_good = fix_type != FIX_NONE && fix_type != FIX_2D; // R7

    // ==========================================================
    // pin drivers
    generate
        for (g = 0; g < NPIN; g++) begin : g_drv
            wire dpf_func_t f = fn_of(func_r, g);
            // auxiliary marks the second falling, so its pulse is inverted
            wire pps_pin = (g == AUX) ? !pps_lvl : pps_lvl; // R5
            assign pin_oe_o[g] = f == FN_PPS_OUT || f == FN_FIX_OUT; // R1
            assign pin_out_o[g] = f == FN_PPS_OUT ? pps_pin : (f == FN_FIX_OUT ? fix_good : 1'b0); // R1 R7
        end
    endgenerate

    // ==========================================================
    // level inputs steering subsystems
    assign stationary_o = lvl_of(func_r, pin_in_i, FN_STILL_IN); // R8
    assign gnss_disable_o = lvl_of(func_r, pin_in_i, FN_GNSS_OFF); // R9
    assign pressure_disable_o = lvl_of(func_r, pin_in_i, FN_PRES_OFF); // R10
    // reverse when the pin sits away from its forward level
    assign reverse_dir_o = lvl_of(func_r, pin_in_i, FN_DIR_FWD_LO) ||
                           lvl_of(func_r, ~pin_in_i, FN_DIR_FWD_HI); // R18
    assign reverse_align_o = lvl_of(func_r, pin_in_i, FN_REV_FWD_LO) ||
                             lvl_of(func_r, ~pin_in_i, FN_REV_FWD_HI); // R19
    assign zero_align_o = |rise_zero; // R11
    assign state_report_req_o = |rise_state; // R13
    assign raw_report_req_o = |rise_raw; // R14
    assign ext_pps_o = ext_sync; // R16
    assign time_valid_o = ctrl_r[CTRL_TVALID]; // R6
    assign irq_o = |(irq_stat_r & irq_en_r);

    // ==========================================================
    // register writes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            func_r <= FUNC_RST;
            ctrl_r <= 32'h0000_0000;
            irq_en_r <= '0;
        end else begin
            if (wr_func) func_r <= (func_r & ~be_mask) | (avs_writedata_i & be_mask);
            if (wr_ctrl) ctrl_r <= (ctrl_r & ~be_mask) | (avs_writedata_i & be_mask);
            if (wr_en) irq_en_r <= avs_writedata_i[IRQ_W-1:0];
        end
    end

    // sticky interrupt status: a new event wins over a clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(wr_clr ? avs_writedata_i[IRQ_W-1:0] : '0)) | events;
        end
    end

    // filter event bits: set on edge, drop after next report; set wins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            evt1_r <= 1'b0;
            evt2_r <= 1'b0;
        end else begin
            evt1_r <= |rise_e1 || (evt1_r && !report_done); // R17
            evt2_r <= |rise_e2 || (evt2_r && !report_done); // R17
        end
    end

    // volatile alignment-zeroed flag; reset loses it, host clears after saving
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            align_set_r <= 1'b0; // R12
        end else begin
            align_set_r <= |rise_zero || (align_set_r && !(wr_align && avs_writedata_i[0]));
        end
    end

    // second counter and edge history
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sec_cnt_r <= 32'h0000_0000;
            started_r <= 1'b0;
            corr_prev_r <= 1'b0;
            pin_prev_r <= '0;
        end else begin
            sec_cnt_r <= sec_cnt_nxt;
            started_r <= started_r || sec_wrap || sec_restart; // R3
            corr_prev_r <= corr_req;
            pin_prev_r <= pin_in_i;
        end
    end

    // ==========================================================
    // read path: one wait cycle, then readdata stands with waitrequest low
    wire [31:0] stat_word = {23'h000000, pps_lvl, evt2_r, evt1_r, time_valid_o, reverse_align_o,
                             reverse_dir_o, stationary_o, pressure_disable_o, gnss_disable_o};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address_i)
            ADDR_FUNC: rd_mux = func_r;
            ADDR_CTRL: rd_mux = ctrl_r;
            ADDR_STAT: rd_mux = stat_word; // R6
            ADDR_IRQ_STAT: rd_mux = 32'(irq_stat_r);
            ADDR_IRQ_EN: rd_mux = 32'(irq_en_r);
            ADDR_ALIGN: rd_mux = {31'h00000000, align_set_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            resp_r <= 2'h0;
        end else begin
            rd_ack_r <= avs_read_i && !rd_ack_r;
            rdata_r <= rd_mux;
            resp_r <= map_hit ? 2'h0 : 2'h2;
        end
    end
    assign avs_waitrequest_o = avs_read_i && !rd_ack_r;
    assign avs_readdata_o = rdata_r;
    assign avs_response_o = rd_ack_r ? resp_r : (map_hit ? 2'h0 : 2'h2);

    // ==========================================================
    // checks
    pps_width_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        $rose(pps_lvl) |-> pps_lvl [*8]) else $error("second pulse too short");
    // a restart may legally begin a new pulse right after a fall, so only quiet seconds are held low
    pps_gap_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        $fell(pps_lvl) && !sec_restart |=> !pps_lvl) else $error("second pulse reappeared at once");
    tri_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        fn_of(func_r, 0) == FN_INACTIVE |-> !pin_oe_o[0]) else $error("inactive pin driven");
    aux_pol_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        fn_of(func_r, AUX) == FN_PPS_OUT |-> pin_out_o[AUX] == !pps_lvl) else $error("aux pulse polarity");
    fix_out_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        fn_of(func_r, 0) == FN_FIX_OUT && fix_type == FIX_2D |-> !pin_out_o[0]) else $error("2D fix drove high");
    gnss_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        fn_of(func_r, 1) == FN_GNSS_OFF && pin_in_i[1] |-> gnss_disable_o) else $error("gnss not disabled");
    still_in_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        fn_of(func_r, 1) == FN_STILL_IN && pin_in_i[1] |-> stationary_o) else $error("stationary not shown");
    rev_dir_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
        fn_of(func_r, 1) == FN_DIR_FWD_HI && !pin_in_i[1] |-> reverse_dir_o) else $error("reverse not shown");
    zero_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        |rise_zero |=> align_set_r) else $error("zeroed flag not set");
    ext_sync_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        ext_sync |=> sec_cnt_r == 32'h0000_0000 && started_r) else $error("second not restarted");
    evt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        |rise_e1 |=> evt1_r) else $error("event bit not set");
    evt_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        evt1_r && report_done && !(|rise_e1) |=> !evt1_r) else $error("event bit not cleared");
    trig_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        state_report_req_o |=> !state_report_req_o) else $error("report request held");
    irq_lvl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        |events |=> (irq_o || (irq_en_r & $past(events)) == '0)) else $error("irq missing");
    pps_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(pps_lvl));
    corr_c: cover property (@(posedge clk_i) disable iff (rst_i) corr_edge && started_r);
    evt_c: cover property (@(posedge clk_i) disable iff (rst_i) evt1_r && report_done);
    ext_c: cover property (@(posedge clk_i) disable iff (rst_i) ext_sync && started_r);
    fix_c: cover property (@(posedge clk_i) disable iff (rst_i) pin_oe_o[0] && pin_out_o[0]);
endmodule

// ===== dpf_ext.sv
// model of the external switches and sensors at the pins
`timescale 1ns/1ps

// ==========================================
// switch and sensor model
module dpf_ext (
    input wire logic clk_i,
    input wire logic [2:0] want_i,
    input wire logic [2:0] out_i,
    input wire logic [2:0] oe_i,
    output logic [2:0] pin_o
);
    logic [2:0] sw_r;

    // contacts move once per clock, already debounced
    always_ff @(posedge clk_i) begin
        sw_r <= want_i;
    end

    // a driven pin shows the device, a released one the switch
    assign pin_o = (oe_i & out_i) | (~oe_i & sw_r);
endmodule

// ===== gpio_dynamic_pin_functions_tb.sv
// self-checking bench for the dynamic pin function block
`timescale 1ns/1ps

// ==========================================
// bench top
module gpio_dynamic_pin_functions_tb;
    import dpf_pkg::*;
    localparam int ST = 20;
    localparam int PER = 100;
    localparam int PW = 10;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [1:0] avs_response_o;
    logic [2:0] want = 3'h0;
    logic [2:0] pin_in, pin_out, pin_oe;
    logic gnss_off, pres_off, still, rev_dir, rev_al, zero_p, state_p, raw_p, ext_p, tvalid, irq;
    logic [1:0] resp_q;
    logic [31:0] d;
    logic [4:0] e;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    int pc [4] = '{0, 0, 0, 0};
    int p [4];
    int t0;
    int w;

    // short counts keep the run brief
    dpf_pins #(.START_CYCLES(ST), .PERIOD_CYCLES(PER), .PULSE_CYCLES(PW)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .avs_response_o(avs_response_o), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .gnss_disable_o(gnss_off), .pressure_disable_o(pres_off), .stationary_o(still),
        .reverse_dir_o(rev_dir), .reverse_align_o(rev_al), .zero_align_o(zero_p),
        .state_report_req_o(state_p), .raw_report_req_o(raw_p), .ext_pps_o(ext_p),
        .time_valid_o(tvalid), .irq_o(irq));

    dpf_ext ext (.clk_i(clk_i), .want_i(want), .out_i(pin_out), .oe_i(pin_oe), .pin_o(pin_in));

    // clock and cycle count since reset
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i or posedge rst_i) begin
        cyc <= rst_i ? 0 : cyc + 1;
    end

    // pulses are tallied, so a stretched pulse counts twice
    always @(posedge clk_i) begin
        pc[0] <= pc[0] + zero_p;
        pc[1] <= pc[1] + state_p;
        pc[2] <= pc[2] + raw_p;
        pc[3] <= pc[3] + ext_p;
    end

    // ==========================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // hold the request until waitrequest is seen low
    task automatic ans();
        int n;
        n = 0;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        // a slave that never answers is a failure, not a silent skip
        if (n >= 20) begin
            fail_count++;
            $display("unexpected at %0t: waitrequest %h exp %h", $time, avs_waitrequest_o, 1'b0);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= v;
        avs_write_i <= 1'b1;
        ans();
        avs_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_read_i <= 1'b1;
        ans();
        d = avs_readdata_o;
        resp_q = avs_response_o;
        avs_read_i <= 1'b0;
    endtask
    task automatic wait_pps(input logic v);
        int n;
        n = 0;
        while (pin_out[0] !== v && n < 2 * PER) begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 2 * PER) begin
            fail_count++;
            $display("unexpected at %0t: pulse pin %h exp %h", $time, pin_out[0], v);
        end
    endtask
    function automatic logic [4:0] lvl_exp(input logic [4:0] c, input logic l);
        logic [4:0] r;
        r = 5'h00;
        case (c)
            FN_STILL_IN: r[4] = l;
            FN_GNSS_OFF: r[3] = l;
            FN_PRES_OFF: r[2] = l;
            FN_DIR_FWD_LO: r[1] = l;
            FN_DIR_FWD_HI: r[1] = !l;
            FN_REV_FWD_LO: r[0] = l;
            FN_REV_FWD_HI: r[0] = !l;
            default: r = 5'h00;
        endcase
        return r;
    endfunction
    task automatic end_of_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // test sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_FUNC);
        chk(d, FUNC_RST);
        chk({29'h0, pin_oe}, 32'h0);
        // second pulse on gpio1 and the aux transmit line
        wr(ADDR_FUNC, 32'h0000_0401);
        wait_pps(1'b1);
        chk(32'(cyc > ST - 4 && cyc < ST + 4), 32'h1);
        chk({31'h0, tvalid}, 32'h0);
        chk({30'h0, pin_out[2], pin_oe[2]}, 32'h1);
        t0 = cyc;
        w = 0;
        while (pin_out[0] === 1'b1 && w < PER) begin
            w++;
            @(posedge clk_i);
        end
        chk(32'(w), PW);
        wait_pps(1'b1);
        chk(32'(cyc - t0), PER);
        // correction mid-second gives a short interval
        repeat (30) @(posedge clk_i);
        t0 = cyc;
        wr(ADDR_CTRL, 32'h0000_0018);
        wait_pps(1'b1);
        chk(32'(cyc - t0 < 6), 32'h1);
        chk({31'h0, tvalid}, 32'h1);
        rd(ADDR_STAT);
        chk({31'h0, d[ST_TVALID]}, 32'h1);
        // fix output over every fix code
        wr(ADDR_FUNC, 32'h0000_0002);
        for (int f = 0; f < 8; f++) begin
            wr(ADDR_CTRL, 32'(f));
            @(posedge clk_i);
            chk({30'h0, pin_out[0], pin_oe[0]}, {30'h0, f > 1, 1'b1});
        end
        // every code on gpio2 at both input levels, one unused code too
        for (int c = 0; c < 17; c++) begin
            wr(ADDR_FUNC, 32'(c) << 5);
            for (int l = 0; l < 2; l++) begin
                want[1] <= l[0];
                repeat (3) @(posedge clk_i);
                e = lvl_exp(5'(c), l[0]);
                chk({27'h0, still, gnss_off, pres_off, rev_dir, rev_al}, {27'h0, e});
                rd(ADDR_STAT);
                chk({27'h0, d[4:0]}, {27'h0, e[0], e[1], e[4], e[2], e[3]});
                chk({31'h0, pin_oe[1]}, 32'(c == 1 || c == 2));
            end
        end
        want[1] <= 1'b0;
        // rising edge modes on the aux receive line
        wr(ADDR_IRQ_EN, 32'h3f);
        for (int c = 6; c < 12; c++) begin
            wr(ADDR_FUNC, 32'(c) << 10);
            wr(ADDR_IRQ_CLR, 32'h3f);
            wr(ADDR_REPORT, 32'h1);
            p = pc;
            want[2] <= 1'b1;
            repeat (4) @(posedge clk_i);
            for (int i = 0; i < 4; i++) begin
                chk(32'(pc[i] - p[i]), 32'(c - 6 == i));
            end
            chk({31'h0, irq}, 32'h1);
            rd(ADDR_IRQ_STAT);
            chk(d, 32'h1 << (c - 6));
            rd(ADDR_STAT);
            chk({30'h0, d[ST_EVT2:ST_EVT1]}, 32'(c > 9 ? c - 9 : 0));
            wr(ADDR_REPORT, 32'h1);
            wr(ADDR_IRQ_CLR, 32'h3f);
            rd(ADDR_STAT);
            chk({30'h0, d[ST_EVT2:ST_EVT1]}, 32'h0);
            chk({31'h0, irq}, 32'h0);
            want[2] <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        // masked event stays pending until enabled
        wr(ADDR_IRQ_EN, 32'h0);
        // the level sweep already zeroed once, so drop that flag before the aux edge
        wr(ADDR_ALIGN, 32'h1);
        rd(ADDR_ALIGN);
        chk(d, 32'h0);
        wr(ADDR_FUNC, 32'h0000_1800);
        want[2] <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        rd(ADDR_IRQ_STAT);
        chk(d, 32'h1);
        wr(ADDR_IRQ_EN, 32'h1);
        @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        rd(ADDR_ALIGN);
        chk(d, 32'h1);
        // unmapped places are refused
        wr(4'hf, 32'hffff_ffff);
        rd(4'h9);
        chk(d, 32'h0);
        chk({30'h0, resp_q}, 32'h2);
        rd(ADDR_FUNC);
        chk(d, 32'h0000_1800);
        // pin-set alignment is lost at reset
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_ALIGN);
        chk(d, 32'h0);
        chk({29'h0, pin_oe}, 32'h0);
        end_of_test();
    end

    // watchdog, about ten thousand cycles
    initial begin
        #400_000;
        fail_count++;
        end_of_test();
    end
endmodule
